// ---- design/fpn_consts.vh ----
`ifndef FPN_CONSTS_VH
`define FPN_CONSTS_VH
`define FPN_CLK_MHZ 250
`define FPN_BLANK_TIME_S 300
`define FPN_BAR_TIME_MS 45000
`define FPN_ALARM_FLASH_MS 2500
`define FPN_DEBOUNCE_US 10000
`define FPN_FLASH_HALF_MS 250
`define FPN_MS_CYCLES (`FPN_CLK_MHZ * 1000)
`define FPN_DEBOUNCE_CYCLES (`FPN_DEBOUNCE_US * `FPN_CLK_MHZ)
`define FPN_BLANK_MS (`FPN_BLANK_TIME_S * 1000)
`define FPN_GRP_BLANK 2'h0
`define FPN_GRP_REV 2'h1
`define FPN_GRP_CHAN 2'h2
`define FPN_GRP_SYS 2'h3
`define FPN_CHAN_CONFIG 2'h0
`define FPN_CHAN_TONE 2'h1
`define FPN_CHAN_CLEAR 2'h2
`define FPN_CHAN_NLP 2'h3
`define FPN_SYS_FIRST 7'h00
`define FPN_SYS_LAST 7'h59
`endif

// ---- design/fpn_debounce.v ----
`timescale 1ns/1ps
`default_nettype none
module fpn_debounce #(
	parameter integer STABLE_CYCLES = 2500000
) (
	input wire clk,
	input wire rst,
	input wire btn_in,
	output reg press_ff
);
	reg sync1_ff;
	reg sync2_ff;
	reg level_ff;
	reg [31:0] cnt_ff;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			level_ff <= 1'b0;
			cnt_ff <= 32'h0;
			press_ff <= 1'b0;
		end else begin
			sync1_ff <= btn_in;
			sync2_ff <= sync1_ff;
			press_ff <= 1'b0;
			if (sync2_ff == level_ff) begin
				cnt_ff <= 32'h0;
			end else if (cnt_ff >= STABLE_CYCLES - 1) begin
				cnt_ff <= 32'h0;
				level_ff <= sync2_ff;
				press_ff <= sync2_ff;
			end else begin
				cnt_ff <= cnt_ff + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- design/fpn_navigator.v ----
`timescale 1ns/1ps
`default_nettype none
`include "fpn_consts.vh"
module fpn_navigator #(
	parameter integer MS_CYCLES = `FPN_MS_CYCLES,
	parameter integer DEBOUNCE_CYCLES = `FPN_DEBOUNCE_CYCLES,
	parameter integer BLANK_MS = `FPN_BLANK_MS,
	parameter integer BAR_MS = `FPN_BAR_TIME_MS,
	parameter integer ALARM_MS = `FPN_ALARM_FLASH_MS,
	parameter integer FLASH_HALF_MS = `FPN_FLASH_HALF_MS,
	parameter [7:0] REV_OPTIONS = 8'h04,
	parameter [7:0] CHAN_OPTIONS = 8'h07,
	parameter [7:0] SYS_OPTIONS = 8'h06
) (
	input wire clk,
	input wire rst,
	input wire mode_btn,
	input wire option_btn,
	input wire chan_btn,
	input wire ds1_present,
	input wire config_valid,
	input wire selftest_done,
	input wire selftest_fail,
	output reg [1:0] mode_group_ff,
	output reg [6:0] mode_index_ff,
	output reg [7:0] option_index_ff,
	output reg display_blank_ff,
	output reg bar_flash_ff,
	output reg option_step_ff,
	output reg power_led_ff,
	output reg send_alarm_led_ff,
	output reg recv_alarm_led_ff,
	output reg fault_led_ff
);
	localparam ST_BAR = 2'h0;
	localparam ST_ALARM = 2'h1;
	localparam ST_RUN = 2'h2;
	wire mode_press;
	wire option_press;
	wire chan_press;
	reg mode_lvl_ff;
	reg chan_lvl_ff;
	reg [31:0] ms_div_ff;
	reg [31:0] idle_ms_ff;
	reg [31:0] pu_ms_ff;
	reg [31:0] flash_ms_ff;
	reg flash_ph_ff;
	reg [1:0] st_ff;
	reg [7:0] opt_limit;
	wire ms_tick = (ms_div_ff == MS_CYCLES - 1);
	fpn_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_mode (
		.clk(clk), .rst(rst), .btn_in(mode_btn), .press_ff(mode_press)
	);
	fpn_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_opt (
		.clk(clk), .rst(rst), .btn_in(option_btn), .press_ff(option_press)
	);
	fpn_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_chan (
		.clk(clk), .rst(rst), .btn_in(chan_btn), .press_ff(chan_press)
	);
	always @* begin
		opt_limit = SYS_OPTIONS;
		if (mode_group_ff == `FPN_GRP_REV) begin
			opt_limit = REV_OPTIONS;
		end else if (mode_group_ff == `FPN_GRP_CHAN) begin
			opt_limit = CHAN_OPTIONS;
		end
	end
	// held levels of mode and channel, for chord detection
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_lvl_ff <= 1'b0;
			chan_lvl_ff <= 1'b0;
		end else begin
			if (mode_press) begin
				mode_lvl_ff <= 1'b1;
			end else if (!mode_btn) begin
				mode_lvl_ff <= 1'b0;
			end
			if (chan_press) begin
				chan_lvl_ff <= 1'b1;
			end else if (!chan_btn) begin
				chan_lvl_ff <= 1'b0;
			end
		end
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ms_div_ff <= 32'h0;
		end else if (ms_tick) begin
			ms_div_ff <= 32'h0;
		end else begin
			ms_div_ff <= ms_div_ff + 32'h1;
		end
	end
	// display navigation
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_group_ff <= `FPN_GRP_BLANK;
			mode_index_ff <= 7'h00;
			option_index_ff <= 8'h00;
			display_blank_ff <= 1'b1;
			option_step_ff <= 1'b0;
			idle_ms_ff <= 32'h0;
		end else begin
			option_step_ff <= 1'b0;
			if (mode_press || option_press || chan_press) begin
				idle_ms_ff <= 32'h0;
			end else if (ms_tick && !display_blank_ff) begin
				idle_ms_ff <= idle_ms_ff + 32'h1;
			end
			if (st_ff != ST_RUN) begin
				display_blank_ff <= 1'b1;
			end else if ((mode_press && (chan_lvl_ff || chan_press)) ||
					(chan_press && mode_lvl_ff)) begin
				mode_group_ff <= `FPN_GRP_BLANK;
				mode_index_ff <= 7'h00;
				option_index_ff <= 8'h00;
				display_blank_ff <= 1'b1;
			end else if (mode_press) begin
				option_index_ff <= 8'h00;
				display_blank_ff <= 1'b0;
				case (mode_group_ff)
					`FPN_GRP_BLANK: begin
						mode_group_ff <= `FPN_GRP_REV;
						mode_index_ff <= 7'h00;
					end
					`FPN_GRP_REV: begin
						mode_group_ff <= `FPN_GRP_CHAN;
						mode_index_ff <= {5'h00, `FPN_CHAN_CONFIG};
					end
					`FPN_GRP_CHAN: begin
						if (mode_index_ff[1:0] == `FPN_CHAN_NLP) begin
							mode_group_ff <= `FPN_GRP_SYS;
							mode_index_ff <= `FPN_SYS_FIRST;
						end else begin
							mode_index_ff <= mode_index_ff + 7'h01;
						end
					end
					default: begin
						if (mode_index_ff == `FPN_SYS_LAST) begin
							mode_group_ff <= `FPN_GRP_BLANK;
							mode_index_ff <= 7'h00;
							display_blank_ff <= 1'b1;
						end else begin
							mode_index_ff <= mode_index_ff + 7'h01;
						end
					end
				endcase
			end else if (option_press && mode_group_ff != `FPN_GRP_BLANK) begin
				// option ignored while blank; step committed via option_step
				option_step_ff <= 1'b1;
				if (option_index_ff >= opt_limit - 8'h01) begin
					option_index_ff <= 8'h00;
				end else begin
					option_index_ff <= option_index_ff + 8'h01;
				end
			end else if (!display_blank_ff && idle_ms_ff >= BLANK_MS - 1 && ms_tick) begin
				mode_group_ff <= `FPN_GRP_BLANK;
				mode_index_ff <= 7'h00;
				option_index_ff <= 8'h00;
				display_blank_ff <= 1'b1;
			end
		end
	end
	// power-up indications, alarm and fault lamps
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= ST_BAR;
			pu_ms_ff <= 32'h0;
			flash_ms_ff <= 32'h0;
			flash_ph_ff <= 1'b0;
			bar_flash_ff <= 1'b0;
			power_led_ff <= 1'b0;
			send_alarm_led_ff <= 1'b0;
			recv_alarm_led_ff <= 1'b0;
			fault_led_ff <= 1'b0;
		end else begin
			power_led_ff <= 1'b1;
			if (selftest_done && selftest_fail) begin
				fault_led_ff <= 1'b1;
			end
			if (ms_tick) begin
				if (flash_ms_ff >= FLASH_HALF_MS - 1) begin
					flash_ms_ff <= 32'h0;
					flash_ph_ff <= ~flash_ph_ff;
				end else begin
					flash_ms_ff <= flash_ms_ff + 32'h1;
				end
			end
			bar_flash_ff <= 1'b0;
			send_alarm_led_ff <= 1'b0;
			recv_alarm_led_ff <= 1'b0;
			case (st_ff)
				ST_BAR: begin
					bar_flash_ff <= flash_ph_ff;
					if (ms_tick) begin
						pu_ms_ff <= pu_ms_ff + 32'h1;
					end
					if (ms_tick && pu_ms_ff >= BAR_MS - 1) begin
						pu_ms_ff <= 32'h0;
						st_ff <= ds1_present ? ST_RUN : ST_ALARM;
					end
				end
				ST_ALARM: begin
					send_alarm_led_ff <= flash_ph_ff;
					recv_alarm_led_ff <= flash_ph_ff;
					if (ms_tick) begin
						pu_ms_ff <= pu_ms_ff + 32'h1;
					end
					if (ms_tick && pu_ms_ff >= ALARM_MS - 1) begin
						st_ff <= ST_RUN;
					end
				end
				default: begin
					send_alarm_led_ff <= ~ds1_present;
					recv_alarm_led_ff <= ~ds1_present;
					if (!config_valid) begin
						send_alarm_led_ff <= 1'b1;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- tb/fpn_navigator_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpn_navigator_monitor (
	input wire clk,
	input wire rst,
	input wire selftest_done,
	input wire selftest_fail,
	input wire [1:0] mode_group_ff,
	input wire [6:0] mode_index_ff,
	input wire [7:0] option_index_ff,
	input wire display_blank_ff,
	input wire option_step_ff,
	input wire power_led_ff,
	input wire fault_led_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_sys_range: assert property (mode_group_ff == 2'h3 |-> mode_index_ff <= 7'h59)
		else $error("system mode past last");
	chk_chan_range: assert property (mode_group_ff == 2'h2 |-> mode_index_ff <= 7'h03)
		else $error("channel mode past last");
	chk_shown_group: assert property (mode_group_ff != 2'h0 |-> !display_blank_ff)
		else $error("mode shown while blank");
	chk_step_pulse: assert property (option_step_ff |=> !option_step_ff)
		else $error("option step too long");
	chk_step_moves: assert property (option_step_ff |-> !$stable(option_index_ff))
		else $error("option step without change");
	chk_step_shown: assert property (option_step_ff |-> mode_group_ff != 2'h0)
		else $error("option step while blank");
	chk_blank_group: assert property ($rose(display_blank_ff) |-> mode_group_ff == 2'h0)
		else $error("blank with mode kept");
	chk_power_lamp: assert property (!rst |=> power_led_ff)
		else $error("power lamp dark");
	chk_fault_latch: assert property (selftest_done && selftest_fail |-> ##[1:3] fault_led_ff)
		else $error("fault lamp not lit");
	chk_fault_hold: assert property (fault_led_ff |=> fault_led_ff)
		else $error("fault lamp dropped");
	cov_step: cover property (option_step_ff);
	cov_blank: cover property ($rose(display_blank_ff));
	cov_fault: cover property ($rose(fault_led_ff));
endmodule
bind fpn_navigator fpn_navigator_monitor mon (.*);
`default_nettype wire

// ---- tb/fpn_navigator_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpn_navigator_tb;
	logic clk = 0, rst = 1, ds1 = 0, cfg = 1, std = 0, stf = 0, seen = 0, dark = 0;
	logic [2:0] hold = 3'h0;
	wire mb, ob, cb, blank, bar, step, pwr, sal, ral, flt;
	wire [1:0] grp;
	wire [6:0] idx;
	wire [7:0] opt;
	int bad_count = 0, check_count = 0;
	// button, group, index, option
	logic [19:0] rows [6] = '{{3'h1, 2'h1, 7'h00, 8'h00}, {3'h2, 2'h1, 7'h00, 8'h01},
		{3'h2, 2'h1, 7'h00, 8'h02}, {3'h1, 2'h2, 7'h00, 8'h00},
		{3'h2, 2'h2, 7'h00, 8'h01}, {3'h1, 2'h2, 7'h01, 8'h00}};
	fpn_operator op (.clk(clk), .hold(hold), .mode_btn(mb), .option_btn(ob), .chan_btn(cb));
	fpn_navigator #(.MS_CYCLES(10), .DEBOUNCE_CYCLES(4), .BLANK_MS(20), .BAR_MS(4),
		.FLASH_HALF_MS(1)) uut (.clk(clk), .rst(rst), .mode_btn(mb),
		.option_btn(ob), .chan_btn(cb), .ds1_present(ds1), .config_valid(cfg),
		.selftest_done(std), .selftest_fail(stf), .mode_group_ff(grp),
		.mode_index_ff(idx), .option_index_ff(opt), .display_blank_ff(blank),
		.bar_flash_ff(bar), .option_step_ff(step), .power_led_ff(pwr),
		.send_alarm_led_ff(sal), .recv_alarm_led_ff(ral), .fault_led_ff(flt));
	initial begin
		forever #2 clk = ~clk;
	end
	task cmp_d(input logic [17:0] g, input logic [17:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %0t display %h expected %h", $time, g, e);
		end
	endtask
	task cmp_l(input logic [1:0] g, input logic [1:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %0t lamp %b expected %b", $time, g, e);
		end
	endtask
	task press(input logic [2:0] b);
		hold <= b;
		repeat (14) @(posedge clk);
		hold <= 3'h0;
		repeat (14) @(posedge clk);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		give_verdict;
	end
	initial begin
		repeat (8) @(posedge clk);
		cmp_l({blank, pwr}, 2'h2);
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (30) begin
			@(posedge clk);
			seen = seen | bar;
		end
		cmp_l({pwr, seen}, 2'h3);
		seen = 1'b0;
		repeat (20) @(posedge clk);
		// send alarm lamp must light and receive alarm lamp must go dark while flashing
		repeat (100) begin
			@(posedge clk);
			seen = seen | sal;
			dark = dark | !ral;
		end
		cmp_l({seen, dark}, 2'h3);
		repeat (25000) @(posedge clk);
		for (int i = 0; i < 3; i++) begin
			cmp_l({sal, ral}, 2'h3);
			repeat (7) @(posedge clk);
		end
		ds1 <= 1'b1;
		repeat (4) @(posedge clk);
		cmp_l({sal, ral}, 2'h0);
		cmp_l({pwr, flt}, 2'h2);
		cfg <= 1'b0;
		repeat (4) @(posedge clk);
		cmp_l({sal, ral}, 2'h2);
		cfg <= 1'b1;
		repeat (4) @(posedge clk);
		cmp_l({sal, ral}, 2'h0);
		press(3'h2);
		cmp_d({grp, idx, opt}, 18'h0);
		for (int i = 0; i < 6; i++) begin
			press(rows[i][19:17]);
			cmp_d({grp, idx, opt}, rows[i][16:0]);
		end
		repeat (7) press(3'h2);
		cmp_d({grp, idx, opt}, {2'h2, 7'h01, 8'h00});
		repeat (3) press(3'h1);
		cmp_d({grp, idx, opt}, {2'h3, 7'h00, 8'h00});
		repeat (89) press(3'h1);
		cmp_d({grp, idx, opt}, {2'h3, 7'h59, 8'h00});
		press(3'h1);
		cmp_d({blank, grp, idx, opt}, 18'h20000);
		press(3'h1);
		press(3'h5);
		cmp_d({blank, grp, idx, opt}, 18'h20000);
		press(3'h1);
		repeat (150) @(posedge clk);
		cmp_l({blank, grp == 2'h1}, 2'h1);
		repeat (60) @(posedge clk);
		cmp_l({blank, grp == 2'h1}, 2'h2);
		stf <= 1'b1;
		std <= 1'b1;
		repeat (4) @(posedge clk);
		cmp_l({pwr, flt}, 2'h3);
		give_verdict;
	end
endmodule
`default_nettype wire

// ---- tb/fpn_operator.sv ----
`timescale 1ns/1ps
`default_nettype none
// operator fingers: each change chatters twice before settling
module fpn_operator (
	input wire clk,
	input wire [2:0] hold,
	output wire mode_btn,
	output wire option_btn,
	output wire chan_btn
);
	logic [2:0] prev = 3'h0;
	logic [2:0] chg = 3'h0;
	logic [1:0] cnt = 2'h0;
	always @(posedge clk) begin
		if (hold != prev) begin
			cnt <= 2'h3;
			chg <= hold ^ prev;
		end else if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end
		prev <= hold;
	end
	assign {chan_btn, option_btn, mode_btn} = hold ^ (chg & {3{cnt[0]}});
endmodule
`default_nettype wire
